// ### hdl/alr_pkg.sv
/*
   package for the ambient light level readout: register offsets, field
   positions, hysteresis steps and refresh timing.
   assumes a 125 MHz system clock.
*/
package alr_pkg;
   localparam int          CLK_HZ           = 125_000_000;
   localparam int          REFRESH_MS       = 80;
   localparam int          REFRESH_CYCLES   = (CLK_HZ / 1000) * REFRESH_MS;
   localparam int          VALUE_W          = 13;
   localparam int          LOW_W            = 8;
   localparam int          HIGH_W           = VALUE_W - LOW_W;
   localparam logic [7:0]  OFF_DARK_THR     = 8'h1F;
   localparam logic [7:0]  OFF_DARK_HYS     = 8'h20;
   localparam logic [7:0]  OFF_S1_LOW       = 8'h21;
   localparam logic [7:0]  OFF_S1_HIGH      = 8'h22;
   localparam logic [7:0]  OFF_S2_LOW       = 8'h23;
   localparam logic [7:0]  OFF_S2_HIGH      = 8'h24;
   localparam logic [7:0]  DARK_THR_RESET   = 8'h00;
   localparam logic [7:0]  DARK_HYS_RESET   = 8'h00;
   localparam logic [7:0]  RESERVED_READ    = 8'h00;
   // one code step is 0.54 uA, so currents are kept in units of 10 nA
   localparam logic [15:0] STEP_10NA        = 16'h0036;
   localparam int          CUR_W            = 16;
endpackage

// ### hdl/alr_sensor_channel.sv
/*
   one sensor channel: takes a conversion value every refresh tick while
   enabled and holds it stable while the host is midway through a pair read.
   assumes the conversion value is already synchronous to sys_clk_in.
*/
`timescale 1ns/1ps
module alr_sensor_channel
   import alr_pkg::*;
#(
   parameter int WIDTH = VALUE_W
)
(
   input  wire logic             sys_clk_in,
   input  wire logic             rst_in,
   input  wire logic             enable_in,
   input  wire logic             tick_in,
   input  wire logic             lock_in,
   input  wire logic [WIDTH-1:0] value_in,
   output logic      [WIDTH-1:0] result_out
);
   logic pending_reg;

   // the value must split into a full low byte and a high byte of one to eight bits
   if (WIDTH < 9 || WIDTH > 16)
   begin : g_width_check
      $error("width unsupported");
   end

   // a tick during a locked pair is deferred, and dropped only if the channel is disabled
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         result_out  <= '0;
         pending_reg <= 1'b0;
      end
      else if (enable_in && (tick_in || pending_reg))
      begin
         if (lock_in)
            pending_reg <= 1'b1;
         else
         begin
            result_out  <= value_in;
            pending_reg <= 1'b0;
         end
      end
      else if (!enable_in)
         pending_reg <= 1'b0;
   end
endmodule

// ### hdl/alr_readout.sv
/*
   ambient light readout: dark level comparator with hysteresis and the
   two read-only sensor result registers on a simple byte register port.
   assumes sensor values and the comparator current come from synchronous
   logic; the sensor enable is a pin and is synchronised here.
*/
`timescale 1ns/1ps
module alr_readout
   import alr_pkg::*;
#(
   parameter int REFRESH = REFRESH_CYCLES
)
(
   input  wire logic               sys_clk_in,
   input  wire logic               rst_in,
   input  wire logic               sense_enable_in,
   input  wire logic [VALUE_W-1:0] sensor1_value_in,
   input  wire logic [VALUE_W-1:0] sensor2_value_in,
   input  wire logic [CUR_W-1:0]   sensor_current_in,
   input  wire logic               reg_wr_in,
   input  wire logic               reg_rd_in,
   input  wire logic [7:0]         reg_addr_in,
   input  wire logic [7:0]         reg_wdata_in,
   output logic      [7:0]         reg_rdata_out,
   output logic                    dark_level_out,
   output logic                    office_level_out
);
   localparam int      N_SENSORS = 2;
   logic [31:0]        tick_cnt_reg;
   logic               tick_reg;
   logic               en_meta_reg;
   logic               en_sync_reg;
   logic [7:0]         dark_threshold_reg;
   logic [7:0]         dark_hysteresis_reg;
   logic               lock_reg  [N_SENSORS];
   logic               lock_now  [N_SENSORS];
   logic [VALUE_W-1:0] value_arr [N_SENSORS];
   logic [VALUE_W-1:0] res_arr   [N_SENSORS];
   logic [CUR_W-1:0]   thr_cur;
   logic [CUR_W-1:0]   hys_cur;
   logic [CUR_W:0]     upper_cur;
   logic [7:0]         rdata_next;
   logic               below_thr;
   logic               above_upper;

   // the counter needs an idle count between two ticks
   if (REFRESH < 2)
   begin : g_refresh_check
      $error("refresh period too short");
   end

   // the high byte below pads exactly three reserved bits
   if (HIGH_W != 5 || LOW_W != 8)
   begin : g_layout_check
      $error("result byte layout unsupported");
   end

   // the top threshold code must fit the current width
   if (CUR_W < 14)
   begin : g_current_check
      $error("current width too narrow");
   end

   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         en_meta_reg <= 1'b0;
         en_sync_reg <= 1'b0;
      end
      else
      begin
         en_meta_reg <= sense_enable_in;
         en_sync_reg <= en_meta_reg;
      end
   end

   // refresh period only runs while sensing is enabled
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end
      else if (!en_sync_reg)
      begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end
      else if (tick_cnt_reg == 32'(REFRESH - 1))
      begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b1;
      end
      else
      begin
         tick_cnt_reg <= tick_cnt_reg + 32'h1;
         tick_reg     <= 1'b0;
      end
   end

   // only threshold and hysteresis accept writes
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         dark_threshold_reg  <= DARK_THR_RESET;
         dark_hysteresis_reg <= DARK_HYS_RESET;
      end
      else if (reg_wr_in)
      begin
         if (reg_addr_in == OFF_DARK_THR)
            dark_threshold_reg <= reg_wdata_in;
         else if (reg_addr_in == OFF_DARK_HYS)
            dark_hysteresis_reg <= reg_wdata_in;
      end
   end

   assign value_arr[0] = sensor1_value_in;
   assign value_arr[1] = sensor2_value_in;

   // one pair lock and one result channel per sensor
   for (genvar i = 0; i < N_SENSORS; i++)
   begin : g_chan
      localparam logic [7:0] LOW_OFF  = (i == 0) ? OFF_S1_LOW : OFF_S2_LOW;
      localparam logic [7:0] HIGH_OFF = (i == 0) ? OFF_S1_HIGH : OFF_S2_HIGH;
      logic                  low_rd;
      logic                  high_rd;

      assign low_rd  = reg_rd_in && (reg_addr_in == LOW_OFF);
      assign high_rd = reg_rd_in && (reg_addr_in == HIGH_OFF);

      // low byte read locks the pair until the high byte is read
      always_ff @(posedge sys_clk_in or posedge rst_in)
      begin
         if (rst_in)
            lock_reg[i] <= 1'b0;
         else if (low_rd)
            lock_reg[i] <= 1'b1;
         else if (high_rd)
            lock_reg[i] <= 1'b0;
      end

      // the low read edge itself holds off a tick too, else the low byte
      // comes from the old conversion and the high byte from the new one
      assign lock_now[i] = lock_reg[i] || low_rd;

      alr_sensor_channel #(
         .WIDTH      (VALUE_W)
      ) u_sensor (
         .sys_clk_in (sys_clk_in),
         .rst_in     (rst_in),
         .enable_in  (en_sync_reg),
         .tick_in    (tick_reg),
         .lock_in    (lock_now[i]),
         .value_in   (value_arr[i]),
         .result_out (res_arr[i])
      );
   end

   always_comb
   begin
      case (reg_addr_in)
         OFF_DARK_THR: rdata_next = dark_threshold_reg;
         OFF_DARK_HYS: rdata_next = dark_hysteresis_reg;
         OFF_S1_LOW:   rdata_next = res_arr[0][LOW_W-1:0];
         OFF_S1_HIGH:  rdata_next = {3'h0, res_arr[0][VALUE_W-1:LOW_W]};
         OFF_S2_LOW:   rdata_next = res_arr[1][LOW_W-1:0];
         OFF_S2_HIGH:  rdata_next = {3'h0, res_arr[1][VALUE_W-1:LOW_W]};
         default:      rdata_next = RESERVED_READ;
      endcase
   end

   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
         reg_rdata_out <= 8'h00;
      else if (reg_rd_in)
         reg_rdata_out <= rdata_next;
   end

   // currents in 10 nA units; 255 codes reach 137.7 uA
   assign thr_cur   = CUR_W'(dark_threshold_reg * STEP_10NA);
   assign hys_cur   = CUR_W'(dark_hysteresis_reg * STEP_10NA);
   assign upper_cur = {1'b0, thr_cur} + {1'b0, hys_cur};

   // strict compares: a current sitting on a trip point keeps the level
   assign below_thr   = sensor_current_in < thr_cur;
   assign above_upper = {1'b0, sensor_current_in} > upper_cur;

   // between the two trip points the level holds
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         dark_level_out   <= 1'b0;
         office_level_out <= 1'b1;
      end
      else if (!dark_level_out && below_thr)
      begin
         dark_level_out   <= 1'b1;
         office_level_out <= 1'b0;
      end
      else if (dark_level_out && above_upper)
      begin
         dark_level_out   <= 1'b0;
         office_level_out <= 1'b1;
      end
   end
endmodule

// ### bench/alr_sensor_model.sv
/*
   sensor pair model: two synchronous 13-bit conversion values.
   assumes the bench sets the values it wants converted.
*/
`timescale 1ns/1ps
module alr_sensor_model
   import alr_pkg::*;
(
   input  wire logic               sys_clk_in,
   input  wire logic [VALUE_W-1:0] set1_in,
   input  wire logic [VALUE_W-1:0] set2_in,
   output logic      [VALUE_W-1:0] s1_out,
   output logic      [VALUE_W-1:0] s2_out
);
   // values move on edges only, like a real converter output
   always_ff @(posedge sys_clk_in)
   begin
      s1_out <= set1_in;
      s2_out <= set2_in;
   end
endmodule

// ### bench/alr_readout_props.sv
/*
   port checker for the light readout.
   assumes it is bound to alr_readout and sees only its ports.
*/
`timescale 1ns/1ps
module alr_readout_props
   import alr_pkg::*;
#(
   parameter int REFRESH = REFRESH_CYCLES
)
(
   input wire logic               sys_clk_in,
   input wire logic               rst_in,
   input wire logic               sense_enable_in,
   input wire logic [VALUE_W-1:0] sensor1_value_in,
   input wire logic [VALUE_W-1:0] sensor2_value_in,
   input wire logic [CUR_W-1:0]   sensor_current_in,
   input wire logic               reg_wr_in,
   input wire logic               reg_rd_in,
   input wire logic [7:0]         reg_addr_in,
   input wire logic [7:0]         reg_wdata_in,
   input wire logic [7:0]         reg_rdata_out,
   input wire logic               dark_level_out,
   input wire logic               office_level_out
);
   logic [7:0] thr_reg;
   logic [7:0] hys_reg;
   int         cur;
   int         lo_lim;
   int         hi_lim;
   // shadow copies, so trip points are known without peeking inside
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         thr_reg <= DARK_THR_RESET;
         hys_reg <= DARK_HYS_RESET;
      end
      else if (reg_wr_in && reg_addr_in == OFF_DARK_THR)
         thr_reg <= reg_wdata_in;
      else if (reg_wr_in && reg_addr_in == OFF_DARK_HYS)
         hys_reg <= reg_wdata_in;
   end
   assign cur = int'(sensor_current_in);
   assign lo_lim = int'(thr_reg) * int'(STEP_10NA);
   assign hi_lim = (int'(thr_reg) + int'(hys_reg)) * int'(STEP_10NA);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   property p_enter_dark;
      !dark_level_out && cur < lo_lim |=> dark_level_out;
   endproperty
   property p_leave_dark;
      dark_level_out && cur > hi_lim |=> !dark_level_out;
   endproperty
   property p_hys_hold;
      dark_level_out && cur <= hi_lim |=> dark_level_out;
   endproperty
   property p_level_pair;
      office_level_out == !dark_level_out;
   endproperty
   property p_hys_read;
      reg_rd_in && reg_addr_in == OFF_DARK_HYS |=> reg_rdata_out == hys_reg;
   endproperty
   property p_s1_reserved;
      reg_rd_in && reg_addr_in == OFF_S1_HIGH |=> reg_rdata_out[7:5] == 3'h0;
   endproperty
   property p_s2_reserved;
      reg_rd_in && reg_addr_in == OFF_S2_HIGH |=> reg_rdata_out[7:5] == 3'h0;
   endproperty
   property p_rdata_hold;
      !reg_rd_in |=> $stable(reg_rdata_out);
   endproperty
   property p_unmapped;
      reg_rd_in && (reg_addr_in < OFF_DARK_THR || reg_addr_in > OFF_S2_HIGH)
         |=> reg_rdata_out == RESERVED_READ;
   endproperty
   a_enter_dark: assert property (p_enter_dark) else $error("no dark entry");
   a_leave_dark: assert property (p_leave_dark) else $error("no office return");
   a_hys_hold: assert property (p_hys_hold) else $error("left dark early");
   a_level_pair: assert property (p_level_pair) else $error("levels disagree");
   a_hys_read: assert property (p_hys_read) else $error("bad hysteresis read");
   a_s1_reserved: assert property (p_s1_reserved) else $error("s1 reserved set");
   a_s2_reserved: assert property (p_s2_reserved) else $error("s2 reserved set");
   a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
   a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
   c_dark: cover property (!dark_level_out ##1 dark_level_out);
   c_office: cover property (dark_level_out ##1 !dark_level_out);
   c_high_read: cover property (reg_rd_in && reg_addr_in == OFF_S1_HIGH);
endmodule

bind alr_readout alr_readout_props #(.REFRESH(REFRESH)) i_alr_readout_props (
   .sys_clk_in, .rst_in, .sense_enable_in, .sensor1_value_in, .sensor2_value_in,
   .sensor_current_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
   .reg_rdata_out, .dark_level_out, .office_level_out);

// ### bench/alr_readout_tb.sv
/*
   testbench for the light readout: register reads, refresh, comparator.
   assumes REFRESH of 16 cycles and the sensor model at the inputs.
*/
`timescale 1ns/1ps
module alr_readout_tb
   import alr_pkg::*;
;
   logic        sys_clk, rst, en, rd, wr, dark, office;
   logic [7:0]  addr, wdata, rdata;
   logic [12:0] set1, set2, v1, v2;
   logic [15:0] cur;
   int          miscompares = 0, n_checks = 0, cycles = 0;
   logic [7:0]  offs [7] = '{OFF_DARK_THR, OFF_DARK_HYS, OFF_S1_LOW, OFF_S1_HIGH,
                             OFF_S2_LOW, OFF_S2_HIGH, 8'h30};
   alr_sensor_model i_alr_sensor_model (.sys_clk_in(sys_clk), .set1_in(set1),
      .set2_in(set2), .s1_out(v1), .s2_out(v2));
   alr_readout #(.REFRESH(16)) i_alr_readout (.sys_clk_in(sys_clk), .rst_in(rst),
      .sense_enable_in(en), .sensor1_value_in(v1), .sensor2_value_in(v2),
      .sensor_current_in(cur), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .dark_level_out(dark),
      .office_level_out(office));
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic complete_run;
      if (miscompares == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // an idle edge, then one strobe cycle, so strobes never merge
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      wait_n(1);
      wr = 1'b1;
      addr = a;
      wdata = d;
      wait_n(1);
      wr = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      wait_n(1);
      rd = 1'b1;
      addr = a;
      wait_n(1);
      rd = 1'b0;
      chk(rdata, e);
   endtask
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         complete_run();
      end
   end
   initial
   begin
      rst = 1'b1;
      {en, rd, wr} = 3'h0;
      {addr, wdata} = 16'h0000;
      {set1, set2} = 26'h0;
      cur = 16'h03E8;
      wait_n(12);
      rst = 1'b0;
      foreach (offs[i]) rd_chk(offs[i], 8'h00);
      set1 = 13'h1ABC;
      set2 = 13'h0567;
      en = 1'b1;
      wait_n(24);
      rd_chk(OFF_S1_LOW, set1[7:0]);
      rd_chk(OFF_S1_HIGH, {3'h0, set1[12:8]});
      rd_chk(OFF_S2_LOW, set2[7:0]);
      rd_chk(OFF_S2_HIGH, {3'h0, set2[12:8]});
      wr_reg(OFF_S1_HIGH, 8'hFF);
      rd_chk(OFF_S1_HIGH, 8'h1A);
      rd_chk(OFF_S1_LOW, 8'hBC);
      set1 = 13'h0F0F;
      set2 = 13'h1FFF;
      wait_n(40);
      rd_chk(OFF_S2_HIGH, 8'h1F);
      rd_chk(OFF_S1_HIGH, 8'h1A);
      rd_chk(OFF_S1_LOW, 8'h0F);
      rd_chk(OFF_S1_HIGH, 8'h0F);
      en = 1'b0;
      set1 = 13'h0AAA;
      wait_n(40);
      rd_chk(OFF_S1_LOW, 8'h0F);
      rd_chk(OFF_S1_HIGH, 8'h0F);
      set1 = 13'h1555;
      en = 1'b1;
      // low read lands on the very edge of the first refresh
      wait_n(17);
      rd_chk(OFF_S1_LOW, 8'h0F);
      rd_chk(OFF_S1_HIGH, 8'h0F);
      rd_chk(OFF_S1_LOW, 8'h55);
      rd_chk(OFF_S1_HIGH, 8'h15);
      wr_reg(OFF_DARK_HYS, 8'hFF);
      rd_chk(OFF_DARK_HYS, 8'hFF);
      wr_reg(OFF_DARK_THR, 8'h10);
      wr_reg(OFF_DARK_HYS, 8'h04);
      cur = 16'h0010 * STEP_10NA - 16'h0001;
      wait_n(3);
      chk({6'h00, dark, office}, 8'h02);
      cur = 16'h0014 * STEP_10NA;
      wait_n(3);
      chk({6'h00, dark, office}, 8'h02);
      cur = 16'h0014 * STEP_10NA + 16'h0001;
      wait_n(3);
      chk({6'h00, dark, office}, 8'h01);
      complete_run();
   end
endmodule
